// ==== rtl/serial_port_defs.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
// Byte offsets on the register bus
`define OFS_STATUS_ONE 8'h16
`define OFS_DATA_BUFFER 8'h18
`define OFS_CONTROL_ONE 8'h13
`define OFS_CONTROL_TWO 8'h20
`define OFS_CONTROL_THREE 8'h24
// Control one fields
`define C1_MODULE_EN 5
`define C1_NINE_BIT 4
`define C1_WAKE_ADDR 3
`define C1_PARITY_EN 1
`define C1_PARITY_ODD 0
// Control two fields
`define C2_TXE_IE 7
`define C2_TXD_IE 6
`define C2_RXF_IE 5
`define C2_IDLE_IE 4
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_STANDBY 1
`define C2_BREAK 0
// Control three fields
`define C3_RX9 7
`define C3_TX9 6
`define C3_RX_XFER 5
`define C3_TX_XFER 4
`define C3_OR_IE 3
`define C3_NF_IE 2
`define C3_FE_IE 1
`define C3_PE_IE 0
// Status one fields
`define S1_TXE 7
`define S1_TXD 6
`define S1_RXF 5
`define S1_IDLE 4
`define S1_OR 3
`define S1_NF 2
`define S1_FE 1
`define S1_PE 0
// Reset values
`define RST_CONTROL 8'h00
`define RST_STATUS_ONE 8'hc0
// Bit time in system clocks (oversampled by 16)
`define BIT_CLKS 16'd16
`define SAMPLE_MID 16'd8
`endif

// ==== rtl/shift_counter.v ====
// Bit timer and bit counter used by the transmitter; the receiver keeps its own timer
`timescale 1ns/10ps
module shift_counter #(
  parameter WIDTH = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire restart_i,
  input wire [WIDTH-1:0] period_i,
  output reg tick_o,
  output reg [3:0] bits_o
);
  reg [WIDTH-1:0] count;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || restart_i) begin
      // Restart arrives a cycle late, so the first bit starts at one
      count <= {{(WIDTH-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
      bits_o <= 4'h0;
    end else if (count == period_i - 1'b1) begin
      count <= {WIDTH{1'b0}};
      tick_o <= 1'b1;
      bits_o <= bits_o + 4'h1;
    end else begin
      count <= count + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule // shift_counter

// ==== rtl/serial_port_control_status.v ====
// Serial port transmit, receive, flag and register logic
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port_control_status (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  output reg [7:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_line_i,
  output reg tx_line_o,
  output wire tx_line_oe_o,
  output wire tx_irq_o,
  output wire rx_irq_o,
  output wire err_irq_o
);
  localparam TX_IDLE = 4'b0001;
  localparam TX_PRE = 4'b0010;
  localparam TX_DATA = 4'b0100;
  localparam TX_BRK = 4'b1000;
  // ==========================================================
  // Registers
  reg [7:0] control_one;
  reg [7:0] control_two;
  reg [5:0] control_three;
  reg tx_ninth_bit;
  reg rx_ninth_bit;
  reg [7:0] tx_hold;
  reg [7:0] rx_hold;
  reg tx_empty_flag, rx_full_flag, idle_flag, overrun_flag;
  reg noise_flag, framing_error_flag, parity_error_flag;
  reg [7:0] seen;
  wire module_enable = control_one[`C1_MODULE_EN];
  wire nine = control_one[`C1_NINE_BIT];
  wire transmitter_on = control_two[`C2_TX_ON];
  wire receiver_on = control_two[`C2_RX_ON];
  wire receiver_standby = control_two[`C2_STANDBY];
  wire send_break_ctl = control_two[`C2_BREAK];
  wire [3:0] frame_bits = nine ? 4'd11 : 4'd10;
  // ==========================================================
  // Bus slave
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;
  wire st_rd = rd && wb_adr_i == `OFS_STATUS_ONE;
  wire dat_rd = rd && wb_adr_i == `OFS_DATA_BUFFER;
  wire dat_wr = wr && wb_adr_i == `OFS_DATA_BUFFER;
  wire tx_done_flag;
  wire [7:0] status_one = {tx_empty_flag, tx_done_flag, rx_full_flag,
    idle_flag, overrun_flag, noise_flag, framing_error_flag,
    parity_error_flag};
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        case (wb_adr_i)
          `OFS_STATUS_ONE: wb_dat_o <= status_one;
          `OFS_DATA_BUFFER: wb_dat_o <= rx_hold;
          `OFS_CONTROL_ONE: wb_dat_o <= control_one;
          `OFS_CONTROL_TWO: wb_dat_o <= control_two;
          `OFS_CONTROL_THREE:
            wb_dat_o <= {rx_ninth_bit, tx_ninth_bit, control_three};
          default: wb_dat_o <= 8'h00;
        endcase
      end
    end
  end
  // ==========================================================
  // Input synchroniser
  reg rx_meta, rx_sync;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_line_i;
      rx_sync <= rx_meta;
    end
  end
  // ==========================================================
  // Transmitter
  reg [3:0] tx_state;
  reg [10:0] tx_shift;
  reg tx_restart;
  reg idle_queued, break_latched;
  reg te_prev;
  reg break_end_one;
  wire tx_tick;
  wire [3:0] tx_bits;
  shift_counter #(.WIDTH(16)) tx_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(tx_restart),
    .period_i(`BIT_CLKS),
    .tick_o(tx_tick),
    .bits_o(tx_bits)
  );
  wire frame_end = tx_tick && tx_bits == frame_bits;
  wire te_rise = transmitter_on && !te_prev;
  // Done is combinational so it drops the cycle work is queued
  assign tx_done_flag = tx_empty_flag && tx_state == TX_IDLE &&
    !(transmitter_on && (!tx_empty_flag || send_break_ctl ||
    idle_queued || te_rise));
  assign tx_line_oe_o = module_enable &&
    (transmitter_on || tx_state != TX_IDLE);
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_line_o <= 1'b1;
      tx_restart <= 1'b1;
      tx_empty_flag <= 1'b1;
      idle_queued <= 1'b0;
      break_latched <= 1'b0;
      te_prev <= 1'b0;
    end else begin
      te_prev <= transmitter_on;
      tx_restart <= 1'b0;
      if (te_rise && tx_state != TX_IDLE)
        idle_queued <= 1'b1;
      if (send_break_ctl)
        break_latched <= 1'b1;
      if (dat_wr && seen[`S1_TXE])
        tx_empty_flag <= 1'b0;
      if (!module_enable)
        tx_empty_flag <= 1'b1;
      case (tx_state)
        TX_IDLE: begin
          tx_line_o <= 1'b1;
          tx_restart <= 1'b1;
          // Start on the next cycle, well inside 1.5 bit times
          if (transmitter_on && module_enable) begin
            if (break_latched || send_break_ctl) begin
              tx_state <= TX_BRK;
              break_latched <= 1'b0;
              tx_line_o <= 1'b0;
              tx_restart <= 1'b0;
            end else if (te_rise || idle_queued) begin
              tx_state <= TX_PRE;
              idle_queued <= 1'b0;
              tx_restart <= 1'b0;
            end else if (!tx_empty_flag) begin
              tx_state <= TX_DATA;
              tx_shift <= {1'b1, tx_ninth_bit, tx_hold, 1'b0};
              if (!nine)
                tx_shift <= {2'b11, tx_hold, 1'b0};
              tx_empty_flag <= 1'b1;
              tx_line_o <= 1'b0;
              tx_restart <= 1'b0;
            end
          end
        end
        TX_PRE: begin
          tx_line_o <= 1'b1;
          if (frame_end) begin
            tx_state <= TX_IDLE;
            tx_restart <= 1'b1;
          end
        end
        TX_DATA: begin
          if (tx_tick)
            tx_shift <= {1'b1, tx_shift[10:1]};
          tx_line_o <= tx_tick ? tx_shift[1] : tx_shift[0];
          if (frame_end) begin
            tx_state <= TX_IDLE;
            tx_line_o <= 1'b1;
            tx_restart <= 1'b1;
          end
        end
        TX_BRK: begin
          tx_line_o <= 1'b0;
          if (frame_end) begin
            // Held break goes straight into the next one
            if (send_break_ctl) begin
              tx_restart <= 1'b1;
              break_latched <= 1'b0;
            end else begin
              tx_state <= TX_PRE;
              tx_line_o <= 1'b1;
              tx_restart <= 1'b1;
              idle_queued <= 1'b0;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
      // Trailing one after a break is one bit, not a full preamble
      if (tx_state == TX_PRE && tx_tick && break_end_one)
        tx_state <= TX_IDLE;
    end
  end
  always @(posedge sys_clk_i) begin
    if (!rst_n_i)
      break_end_one <= 1'b0;
    else if (tx_state == TX_BRK && frame_end && !send_break_ctl)
      break_end_one <= 1'b1;
    else if (tx_state != TX_PRE)
      break_end_one <= 1'b0;
  end
  // ==========================================================
  // Receiver
  reg [2:0] rx_phase;
  reg [10:0] rx_shift;
  reg [3:0] rx_count;
  reg [15:0] rx_timer;
  reg [8:0] ones_count;
  reg idle_armed;
  reg [2:0] votes;
  reg noisy;
  wire rx_active = rx_phase != 3'b001;
  wire mid = rx_timer == `SAMPLE_MID;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_phase <= 3'b001;
      rx_shift <= 11'h000;
      rx_count <= 4'h0;
      rx_timer <= 16'h0000;
      votes <= 3'b111;
      noisy <= 1'b0;
    end else if (!receiver_on || !module_enable) begin
      rx_phase <= 3'b001;
      rx_timer <= 16'h0000;
    end else begin
      votes <= {votes[1:0], rx_sync};
      if (!rx_active) begin
        if (!rx_sync) begin
          rx_phase <= 3'b010;
          rx_timer <= 16'h0000;
          rx_count <= 4'h0;
          noisy <= 1'b0;
        end
      end else begin
        rx_timer <= (rx_timer == `BIT_CLKS - 16'd1) ? 16'h0000 :
          rx_timer + 16'd1;
        if (mid) begin
          // Disagreeing samples around mid-bit count as noise
          if (!(votes == 3'b000 || votes == 3'b111))
            noisy <= 1'b1;
          rx_shift <= {rx_sync, rx_shift[10:1]};
          rx_count <= rx_count + 4'h1;
          if (rx_count == 4'h0 && rx_sync)
            rx_phase <= 3'b001;
          else if (rx_count == frame_bits - 4'h1)
            rx_phase <= 3'b100;
        end
        if (rx_phase == 3'b100)
          rx_phase <= 3'b001;
      end
    end
  end
  wire rx_done = rx_phase == 3'b100;
  wire [8:0] rx_word = nine ? rx_shift[9:1] : {1'b0, rx_shift[10:3]};
  wire [7:0] rx_byte = nine ? rx_shift[8:1] : rx_shift[9:2];
  wire rx_stop = rx_shift[10];
  wire par_bit = rx_shift[9];
  wire par_calc = nine ? ^rx_shift[8:1] : ^rx_shift[8:2];
  wire par_bad = control_one[`C1_PARITY_EN] &&
    ((par_calc ^ par_bit ^ control_one[`C1_PARITY_ODD]) != 1'b0);
  wire rx_msb = rx_shift[9];
  // Quiet is a whole frame of high bit times, counted in clocks
  wire [8:0] quiet_clks = {1'b0, frame_bits, 4'h0};
  wire quiet_now = ones_count == quiet_clks;
  // Wake on the moment the line turns quiet, not while it stays so
  wire quiet_hit = receiver_on && rx_sync && !rx_active &&
    ones_count == quiet_clks - 9'h001;
  // ==========================================================
  // Flags and clearing sequence
  always @(posedge sys_clk_i) begin
    if (!rst_n_i)
      seen <= 8'h00;
    else if (st_rd)
      seen <= status_one;
    else if (dat_rd || dat_wr)
      seen <= 8'h00;
  end
  wire clr_rx = dat_rd;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_full_flag <= 1'b0;
      idle_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      ones_count <= 9'h000;
      idle_armed <= 1'b0;
      rx_ninth_bit <= rx_ninth_bit;
      rx_hold <= rx_hold;
    end else begin
      // Set wins over a clear in the same cycle
      if (clr_rx && seen[`S1_RXF]) rx_full_flag <= 1'b0;
      if (clr_rx && seen[`S1_IDLE]) idle_flag <= 1'b0;
      if (clr_rx && seen[`S1_OR]) overrun_flag <= 1'b0;
      if (clr_rx && seen[`S1_NF]) noise_flag <= 1'b0;
      if (clr_rx && seen[`S1_FE]) framing_error_flag <= 1'b0;
      if (clr_rx && seen[`S1_PE]) parity_error_flag <= 1'b0;
      if (clr_rx && seen[`S1_IDLE]) idle_armed <= 1'b0;
      if (receiver_on && rx_sync && !rx_active) begin
        if (!quiet_now)
          ones_count <= ones_count + 9'h001;
      end else
        ones_count <= 9'h000;
      if (quiet_now && idle_armed && receiver_on) begin
        idle_flag <= 1'b1;
        idle_armed <= 1'b0;
      end
      if (rx_done) begin
        if (rx_full_flag && !(clr_rx && seen[`S1_RXF]))
          overrun_flag <= 1'b1;
        else begin
          rx_hold <= rx_byte;
          rx_ninth_bit <= nine ? rx_word[8] : rx_byte[7];
          rx_full_flag <= 1'b1;
          idle_armed <= 1'b1;
          if (noisy) noise_flag <= 1'b1;
          if (!rx_stop) framing_error_flag <= 1'b1;
          if (par_bad) parity_error_flag <= 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // Control registers
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      control_one <= `RST_CONTROL;
      control_two <= `RST_CONTROL;
      control_three <= 6'h00;
    end else begin
      if (wr && wb_adr_i == `OFS_CONTROL_ONE)
        control_one <= wb_dat_i;
      if (wr && wb_adr_i == `OFS_CONTROL_TWO)
        control_two <= wb_dat_i;
      if (wr && wb_adr_i == `OFS_CONTROL_THREE)
        control_three <= wb_dat_i[5:0];
      // Hardware wake beats a software write in the same cycle
      if (receiver_standby && (control_one[`C1_WAKE_ADDR] ?
          (rx_done && rx_msb) : quiet_hit))
        control_two[`C2_STANDBY] <= 1'b0;
    end
  end
  always @(posedge sys_clk_i) begin
    if (wr && wb_adr_i == `OFS_CONTROL_THREE)
      tx_ninth_bit <= wb_dat_i[`C3_TX9];
    if (dat_wr)
      tx_hold <= wb_dat_i;
  end
  // ==========================================================
  // Interrupt requests
  assign tx_irq_o = module_enable &&
    ((tx_empty_flag && control_two[`C2_TXE_IE]) ||
    (tx_done_flag && control_two[`C2_TXD_IE]));
  assign rx_irq_o = !receiver_standby &&
    ((rx_full_flag && control_two[`C2_RXF_IE]) ||
    (idle_flag && control_two[`C2_IDLE_IE]));
  assign err_irq_o = (overrun_flag && control_three[`C3_OR_IE]) ||
    (noise_flag && control_three[`C3_NF_IE]) ||
    (framing_error_flag && control_three[`C3_FE_IE]) ||
    (parity_error_flag && control_three[`C3_PE_IE]);
endmodule // serial_port_control_status

// ==== verification/serial_port_control_status_props.sv ====
// Checker on bus handshake, transmit framing and request levels
`timescale 1ns/10ps
module serial_port_control_status_props (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_dat_o,
  input wire wb_ack_o,
  input wire tx_line_o,
  input wire tx_line_oe_o,
  input wire rx_irq_o,
  input wire err_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [15:0] low_run;
  // Low run on the wire, so a long break cannot hide a short bit
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || tx_line_o)
      low_run <= 16'h0000;
    else
      low_run <= low_run + 16'h0001;
  end
  // ====================================
  // Assertions
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_prompt: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  a_oe_cause: assert property ($rose(tx_line_oe_o) |->
    wb_ack_o || $past(wb_ack_o))
    else $error("pin driven without a write");
  a_idle_high: assert property (!tx_line_oe_o |-> tx_line_o)
    else $error("released line not idle high");
  a_bit_grid: assert property ($rose(tx_line_o) |->
    low_run[3:0] == 4'h0)
    else $error("low run not whole bit times");
  a_rx_req_fall: assert property ($fell(rx_irq_o) |->
    wb_ack_o || $past(wb_ack_o))
    else $error("receiver request dropped by itself");
  a_err_req_fall: assert property ($fell(err_irq_o) |->
    wb_ack_o || $past(wb_ack_o))
    else $error("error request dropped by itself");
  cover property ($rose(rx_irq_o));
  cover property ($rose(err_irq_o));
  cover property ($fell(tx_line_o));
endmodule // serial_port_control_status_props

// ==== verification/serial_peer.sv ====
// Remote serial peer: drives the receive line, decodes transmit frames
`timescale 1ns/10ps
module serial_peer (
  input wire sys_clk_i,
  input wire tx_line_i,
  output reg rx_line_o
);
  logic [7:0] got [$];
  initial rx_line_o = 1'b1;
  // ====================================
  // Start 0, data lsb first, stop, then one idle bit; 16 clocks a bit
  // Idle bit keeps a bad stop from gluing onto the next start
  task send(input logic [7:0] b, input logic stop);
    logic [10:0] f;
    integer i;
    begin
      f = {1'b1, stop, b, 1'b0};
      for (i = 0; i < 11; i++) begin
        rx_line_o <= f[i];
        repeat (16) @(posedge sys_clk_i);
      end
    end
  endtask
  // ====================================
  // Mid-bit sampling; stop sample ends early to catch a back-to-back start
  always begin : rx_frames
    logic [9:0] f;
    integer i;
    @(posedge sys_clk_i);
    if (tx_line_i === 1'b0) begin
      for (i = 0; i < 10; i++) begin
        repeat (i == 0 ? 7 : 16) @(posedge sys_clk_i);
        f[i] = tx_line_i;
      end
      got.push_back(f[8:1]);
    end
  end
endmodule // serial_peer

// ==== verification/test_serial_port_control_status.sv ====
// Bench: bus tasks, reference queue, scenarios and verdict
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module test_serial_port_control_status;
  reg sys_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [7:0] wb_dat_i = 8'h00;
  wire [7:0] wb_dat_o;
  wire wb_ack_o, rx_line, tx_line_o, tx_line_oe_o;
  wire tx_irq_o, rx_irq_o, err_irq_o;
  // Released pin is pulled up
  wire tx_wire = tx_line_oe_o ? tx_line_o : 1'b1;
  integer mismatches = 0;
  integer compares = 0;
  integer seed = 32'h8c9d7242;
  integer i;
  logic [7:0] q, b1, b2;
  logic [7:0] sent [$];
  always #25 sys_clk_i = ~sys_clk_i;
  serial_port_control_status dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_line_i(rx_line), .tx_line_o(tx_line_o),
    .tx_line_oe_o(tx_line_oe_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .err_irq_o(err_irq_o));
  serial_peer peer (.sys_clk_i(sys_clk_i), .tx_line_i(tx_wire),
    .rx_line_o(rx_line));
  // ====================================
  // Tasks
  task test_done;
    begin
      if (mismatches == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
      compares++;
      if (g !== e) begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge sys_clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge sys_clk_i);
        n++;
      end
      if (n == 20)
        mismatches++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  // Poll status until every bit of m is set
  task poll(input logic [7:0] m);
    integer n;
    begin
      n = 0;
      rd(`OFS_STATUS_ONE);
      while ((q & m) !== m && n < 600) begin
        rd(`OFS_STATUS_ONE);
        n++;
      end
      if (n == 600)
        mismatches++;
    end
  endtask
  // ====================================
  // Scenarios
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`OFS_STATUS_ONE);
    check("status", `RST_STATUS_ONE, q);
    rd(`OFS_CONTROL_TWO);
    check("control_two", `RST_CONTROL, q);
    rd(`OFS_CONTROL_THREE);
    check("control_three", 8'h00, q & 8'h3f);
    wb(1'b1, 8'h30, 8'hff);
    rd(8'h30);
    check("unmapped", 8'h00, q);
    wb(1'b1, `OFS_CONTROL_ONE, 8'h20);
    wb(1'b1, `OFS_CONTROL_TWO, 8'h2c);
    rd(`OFS_CONTROL_TWO);
    check("control_two", 8'h2c, q);
    check("tx_oe", 8'h01, {7'h00, tx_line_oe_o});
    for (i = 0; i < 3; i++) begin
      b1 = $random(seed);
      rd(`OFS_STATUS_ONE);
      wb(1'b1, `OFS_DATA_BUFFER, b1);
      poll(8'hc0);
      check("status", 8'hc0, q);
      check("tx_byte", b1, peer.got.pop_front());
    end
    b1 = $random(seed);
    sent.push_back(b1);
    peer.send(b1, 1'b1);
    poll(8'h30);
    check("status", 8'hf0, q);
    check("rx_irq", 8'h01, {7'h00, rx_irq_o});
    wb(1'b1, `OFS_CONTROL_TWO, 8'h2e);
    @(posedge sys_clk_i);
    check("rx_irq", 8'h00, {7'h00, rx_irq_o});
    wb(1'b1, `OFS_CONTROL_TWO, 8'h2c);
    rd(`OFS_CONTROL_THREE);
    check("rx_ninth", {7'h00, b1[7]}, {7'h00, q[7]});
    rd(`OFS_DATA_BUFFER);
    check("rx_byte", sent.pop_front(), q);
    rd(`OFS_STATUS_ONE);
    check("status", 8'hc0, q);
    check("rx_irq", 8'h00, {7'h00, rx_irq_o});
    // Quiet line alone must not set the flag again until re-armed
    repeat (400) @(posedge sys_clk_i);
    rd(`OFS_STATUS_ONE);
    check("status", 8'hc0, q);
    b1 = $random(seed);
    b2 = $random(seed);
    sent.push_back(b1);
    peer.send(b1, 1'b1);
    peer.send(b2, 1'b1);
    poll(8'h38);
    check("status", 8'hf8, q);
    rd(`OFS_DATA_BUFFER);
    check("rx_byte", sent.pop_front(), q);
    rd(`OFS_STATUS_ONE);
    check("status", 8'hc0, q);
    wb(1'b1, `OFS_CONTROL_THREE, 8'h02);
    b1 = $random(seed);
    peer.send(b1, 1'b0);
    poll(8'h32);
    check("status", 8'hf2, q);
    check("err_irq", 8'h01, {7'h00, err_irq_o});
    rd(`OFS_DATA_BUFFER);
    @(posedge sys_clk_i);
    check("err_irq", 8'h00, {7'h00, err_irq_o});
    test_done;
  end
  // Run needs a few thousand cycles; far longer means a hang
  initial begin
    #(40000 * 50);
    mismatches++;
    test_done;
  end
endmodule // test_serial_port_control_status
bind serial_port_control_status serial_port_control_status_props props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_line_o(tx_line_o), .tx_line_oe_o(tx_line_oe_o),
  .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
